//--- bench/bcm_bus_model.sv
// Source of monitored bus cycles; idle buses show zeros, then the inverted values of the last cycle.
`timescale 1ns/10ps
module bcm_bus_model (
	input wire logic ref_clk,
	output bcm_pkg::bcm_cycle_t bus_cycle,
	output bcm_pkg::bcm_xy_cycle_t xy_cycle
);
	initial bus_cycle = '0;
	initial xy_cycle = '0;
	task automatic issue(input bcm_pkg::bcm_cycle_t m, input bcm_pkg::bcm_xy_cycle_t x);
		@(posedge ref_clk);
		bus_cycle <= m;
		xy_cycle <= x;
		@(posedge ref_clk);
		bus_cycle <= {1'b0, ~m[68:0]};
		xy_cycle <= {1'b0, ~x[35:0]};
	endtask
endmodule

//--- bench/bcm_match_sva.sv
// Port assertions of the break matcher, bound to its top module.
`timescale 1ns/10ps
`include "bcm_cfg.svh"
module bcm_match_sva (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire bcm_pkg::bcm_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire bcm_pkg::bcm_cycle_t bus_cycle,
	input wire bcm_pkg::bcm_xy_cycle_t xy_cycle,
	input wire logic match_a,
	input wire logic match_b
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence acc;
		apb_req.psel && apb_req.penable && !pready;
	endsequence
	sequence ans;
		##1 pready ##1 !pready;
	endsequence
	ready_wait_a: assert property (acc |-> ans) else $error("late ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
	unmapped_err_a: assert property (acc ##0 apb_req.paddr[31:12] != 20'h0 |=> pslverr)
		else $error("no error");
	data_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
	write_zero_a: assert property (pready && apb_req.pwrite |-> prdata == 32'h0)
		else $error("write data");
	cyc_upper_a: assert property (pready && apb_req.paddr[11:0] == `BCM_OFS_A_CYC
		|-> prdata[31:8] == 24'h0) else $error("upper bits set");
	a_cause_a: assert property (match_a |-> $past(bus_cycle.valid))
		else $error("match a without cycle");
	b_cause_a: assert property (match_b |-> $past(bus_cycle.valid || xy_cycle.valid))
		else $error("match b without cycle");
endmodule
bind bcm_match bcm_match_sva i_sva (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_cycle(bus_cycle),
	.xy_cycle(xy_cycle), .match_a(match_a), .match_b(match_b));

//--- bench/tb_break_condition_match.sv
// Bench of the break matcher: APB master, bus cycle scenarios, verdict.
`timescale 1ns/10ps
`include "bcm_cfg.svh"
module tb_break_condition_match;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	bcm_pkg::bcm_apb_req_t apb_req = '0;
	logic [31:0] prdata;
	logic pready, pslverr, match_a, match_b;
	bcm_pkg::bcm_cycle_t bus_cycle;
	bcm_pkg::bcm_xy_cycle_t xy_cycle;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	// Entry: cycle select, master/kind/dir/size, expected match, address pick.
	logic [15:0] tab [12] = '{16'h3c08, 16'h7c0c, 16'h7c88, 16'hbc8c, 16'hdc54, 16'hdc10,
		16'he430, 16'he92c, 16'he930, 16'hde4c, 16'hfc1d, 16'hfc1a};
	always #12.5 ref_clk = ~ref_clk;
	bcm_match i_dut (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_cycle(bus_cycle), .xy_cycle(xy_cycle),
		.match_a(match_a), .match_b(match_b));
	bcm_bus_model i_bus (.ref_clk(ref_clk), .bus_cycle(bus_cycle), .xy_cycle(xy_cycle));
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d, output logic [32:0] r);
		@(posedge ref_clk);
		apb_req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = {pslverr, prdata};
		apb_req <= '0;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input string n, input logic [31:0] a, input logic [32:0] e);
		logic [32:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(n, e, r);
	endtask
	task automatic hit(input logic [5:0] f, input logic [31:0] a, d,
		input bcm_pkg::bcm_xy_cycle_t x, input logic [1:0] e);
		i_bus.issue({f, a, d}, x);
		#1;
		chk("match", {31'h0, e}, {31'h0, match_b, match_a});
	endtask
	task automatic t_regs;
		rd("a_cyc", `BCM_OFS_A_CYC, 33'h0);
		rd("b_addr", `BCM_OFS_B_ADDR, 33'h0);
		rd("b_dmask", `BCM_OFS_B_DMASK, 33'h0);
		wr(`BCM_OFS_A_CYC, 32'hffff_ffff);
		rd("a_cyc", `BCM_OFS_A_CYC, 33'hff);
		rd("unmapped", 32'h0000_1000, 33'h1_0000_0000);
	endtask
	task automatic t_chan_a;
		logic [31:0] a;
		wr(`BCM_OFS_A_ADDR, 32'h1000_0000);
		wr(`BCM_OFS_A_AMASK, 32'h0000_00ff);
		foreach (tab[i]) begin
			wr(`BCM_OFS_A_CYC, {24'h0, tab[i][15:8]});
			a = {7'h08, tab[i][1], 16'h0, tab[i][0] ? 8'hab : 8'h00};
			hit({1'b1, tab[i][7:3]}, a, 32'h0, '0, {1'b0, tab[i][2]});
		end
	endtask
	task automatic t_chan_b;
		wr(`BCM_OFS_B_ADDR, 32'h1234_5678);
		wr(`BCM_OFS_B_CYC, 32'h0fc);
		wr(`BCM_OFS_B_CTRL, 32'h1);
		wr(`BCM_OFS_B_DATA, 32'ha5a5_0000);
		wr(`BCM_OFS_B_DMASK, 32'h0000_ffff);
		hit(6'h23, 32'h1234_5678, 32'ha5a5_1234, '0, 2'b10);
		hit(6'h23, 32'h1234_5679, 32'ha5a5_0000, '0, 2'b00);
		hit(6'h23, 32'h1234_5678, 32'ha4a5_0000, '0, 2'b00);
		wr(`BCM_OFS_B_AMASK, 32'h0000_0001);
		hit(6'h23, 32'h1234_5679, 32'ha5a5_0000, '0, 2'b10);
		wr(`BCM_OFS_B_AMASK, 32'h0000_ffff);
		wr(`BCM_OFS_B_CYC, 32'h2fc);
		hit(6'h00, 32'h0, 32'h0, {5'h10, 16'h1235, 16'ha5a5}, 2'b10);
		hit(6'h23, 32'h1234_5678, 32'ha5a5_0000, '0, 2'b00);
		hit(6'h00, 32'h0, 32'h0, {5'h10, 16'h1334, 16'ha5a5}, 2'b00);
		hit(6'h00, 32'h0, 32'h0, {5'h10, 16'h1234, 16'ha5a4}, 2'b00);
		hit(6'h00, 32'h0, 32'h0, {5'h18, 16'h1234, 16'ha5a5}, 2'b00);
		wr(`BCM_OFS_B_CYC, 32'h3fc);
		hit(6'h00, 32'h0, 32'h0, {5'h18, 16'hbeef, 16'h9999}, 2'b10);
		wr(`BCM_OFS_B_CYC, 32'h1fc);
		wr(`BCM_OFS_B_CTRL, 32'h0);
		hit(6'h23, 32'h1234_5678, 32'h0, '0, 2'b10);
		rd("b_cyc", `BCM_OFS_B_CYC, 33'h1fc);
		rd("b_ctrl", `BCM_OFS_B_CTRL, 33'h0);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_chan_a();
		t_chan_b();
		close_out();
	end
endmodule

//--- logic/bcm_cfg.svh
// Register offsets, field positions, masks and reset values of the break matcher.
`ifndef BCM_CFG_SVH
`define BCM_CFG_SVH
`define BCM_OFS_A_ADDR 12'h000
`define BCM_OFS_A_AMASK 12'h004
`define BCM_OFS_A_CYC 12'h008
`define BCM_OFS_B_ADDR 12'h00c
`define BCM_OFS_B_AMASK 12'h010
`define BCM_OFS_B_CYC 12'h014
`define BCM_OFS_B_DATA 12'h018
`define BCM_OFS_B_DMASK 12'h01c
`define BCM_OFS_B_CTRL 12'h020
`define BCM_OFS_STATUS 12'h024
`define BCM_RST_16 16'h0000
`define BCM_RST_32 32'h0000_0000
`define BCM_CYC_MASK 16'h00ff
`define BCM_CYCB_MASK 16'h03ff
`define BCM_CTRL_MASK 32'h0000_0001
`define BCM_FLD_MASTER_HI 7
`define BCM_FLD_MASTER_LO 6
`define BCM_FLD_KIND_HI 5
`define BCM_FLD_KIND_LO 4
`define BCM_FLD_DIR_HI 3
`define BCM_FLD_DIR_LO 2
`define BCM_FLD_SIZE_HI 1
`define BCM_FLD_SIZE_LO 0
`define BCM_FLD_XY_EN 9
`define BCM_FLD_XY_SEL 8
`define BCM_FLD_DATA_EN 0
`endif

//--- logic/bcm_match.sv
// Break-condition comparator for two channels with an APB register slave.
`timescale 1ns/10ps
`include "bcm_cfg.svh"

// Functional notes
// - Master field: 00 off, 01 CPU only, 10 DMA only, 11 both.
// - Cycle kind field: 00 off, 01 fetch only, 10 data only, 11 both.
// - Direction field: 00 off, 01 read only, 10 write only, 11 both.
// - Size field: 00 any size, 01 byte, 10 word, 11 longword.
// - Channel A cycle register upper byte reads zero; software writes zero.
// - With DMA master chosen every DMA controller cycle is a candidate.
// - Fetches count as word size; data size comes from the access itself.
// - Reset clears the channel A cycle register.
// - Channel A mask bit one drops that address bit from the compare.
// - X/Y off: channel B compares all 32 address bits with the main bus.
// - X/Y on: upper half against X bus, lower half against Y bus.
// - Bit zero of X and Y addresses is never compared.
// - Channel B mask bit one drops that address bit from the compare.
// - X/Y on: upper mask half for X, lower mask half for Y.
// - Data compare: full bus, or upper half to X, lower half to Y.
// - Data mask: both halves, or upper for X, lower for Y.
// - Reset clears both channel B address halves.
// - Reset clears both channel B data mask halves.
// - Channel B data mask bit one drops that data bit from the compare.
// - Byte data sits in bits 7..0 for odd, 15..8 for even addresses.
// - X/Y enable picks main bus or X/Y buses; select valid only when enabled.
module bcm_match (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire bcm_pkg::bcm_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire bcm_pkg::bcm_cycle_t bus_cycle,
	input wire bcm_pkg::bcm_xy_cycle_t xy_cycle,
	output logic match_a,
	output logic match_b
);
	logic [31:0] a_addr_r;
	logic [31:0] a_amask_r;
	logic [15:0] a_cyc_r;
	logic [31:0] b_addr_r;
	logic [31:0] b_amask_r;
	logic [15:0] b_cyc_r;
	logic [31:0] b_data_r;
	logic [31:0] b_dmask_r;
	logic b_data_en_r;
	logic [31:0] prdata_nxt;
	logic hit;
	logic access;
	logic wr_en;
	logic a_hit;
	logic b_hit;

	assign access = apb_req.psel && apb_req.penable;
	assign wr_en = access && apb_req.pwrite && hit;

	// Cycle attribute check shared by both channels; any disabling field blocks the match.
	function automatic logic attr_ok(input logic [7:0] sel, input logic dma, input logic fetch,
		input logic wr, input bcm_pkg::bcm_size_t sz);
		logic m_ok;
		logic k_ok;
		logic d_ok;
		logic s_ok;
		logic [1:0] eff;
		m_ok = dma ? sel[`BCM_FLD_MASTER_HI] : sel[`BCM_FLD_MASTER_LO];
		k_ok = fetch ? sel[`BCM_FLD_KIND_LO] : sel[`BCM_FLD_KIND_HI];
		d_ok = wr ? sel[`BCM_FLD_DIR_HI] : sel[`BCM_FLD_DIR_LO];
		eff = fetch ? 2'(bcm_pkg::BCM_SZ_WORD) : 2'(sz);
		s_ok = (sel[`BCM_FLD_SIZE_HI:`BCM_FLD_SIZE_LO] == 2'h0) ||
			(sel[`BCM_FLD_SIZE_HI:`BCM_FLD_SIZE_LO] == eff);
		attr_ok = m_ok && k_ok && d_ok && s_ok;
	endfunction

	// Address decode and read mux.
	always_comb begin
		hit = 1'b1;
		prdata_nxt = 32'h0000_0000;
		case (apb_req.paddr[11:0])
			`BCM_OFS_A_ADDR: prdata_nxt = a_addr_r;
			`BCM_OFS_A_AMASK: prdata_nxt = a_amask_r;
			`BCM_OFS_A_CYC: prdata_nxt = {16'h0000, a_cyc_r & `BCM_CYC_MASK};
			`BCM_OFS_B_ADDR: prdata_nxt = b_addr_r;
			`BCM_OFS_B_AMASK: prdata_nxt = b_amask_r;
			`BCM_OFS_B_CYC: prdata_nxt = {16'h0000, b_cyc_r & `BCM_CYCB_MASK};
			`BCM_OFS_B_DATA: prdata_nxt = b_data_r;
			`BCM_OFS_B_DMASK: prdata_nxt = b_dmask_r;
			`BCM_OFS_B_CTRL: prdata_nxt = {31'h0000_0000, b_data_en_r};
			`BCM_OFS_STATUS: prdata_nxt = {30'h0000_0000, match_b, match_a};
			default: hit = 1'b0;
		endcase
		if (apb_req.paddr[31:12] != 20'h00000) begin
			hit = 1'b0;
			prdata_nxt = 32'h0000_0000;
		end
	end

	// Slave answers in the second access cycle (one wait state); pready pulses for that cycle.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `BCM_RST_32;
		end else begin
			pready <= apb_req.psel && apb_req.penable && !pready;
			pslverr <= apb_req.psel && apb_req.penable && !pready && !hit;
			// Read data is loaded only for the answering cycle, so it reads zero at all other times.
			prdata <= (access && !pready && !apb_req.pwrite) ? prdata_nxt : `BCM_RST_32;
		end
	end

	// Writes land at the edge where pready is sampled high.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			a_addr_r <= `BCM_RST_32;
			a_amask_r <= `BCM_RST_32;
			a_cyc_r <= `BCM_RST_16;
			b_addr_r <= `BCM_RST_32;
			b_amask_r <= `BCM_RST_32;
			b_cyc_r <= `BCM_RST_16;
			b_data_r <= `BCM_RST_32;
			b_dmask_r <= `BCM_RST_32;
			b_data_en_r <= 1'b0;
		end else if (wr_en && pready) begin
			case (apb_req.paddr[11:0])
				`BCM_OFS_A_ADDR: a_addr_r <= apb_req.pwdata;
				`BCM_OFS_A_AMASK: a_amask_r <= apb_req.pwdata;
				`BCM_OFS_A_CYC: a_cyc_r <= apb_req.pwdata[15:0] & `BCM_CYC_MASK;
				`BCM_OFS_B_ADDR: b_addr_r <= apb_req.pwdata;
				`BCM_OFS_B_AMASK: b_amask_r <= apb_req.pwdata;
				`BCM_OFS_B_CYC: b_cyc_r <= apb_req.pwdata[15:0] & `BCM_CYCB_MASK;
				`BCM_OFS_B_DATA: b_data_r <= apb_req.pwdata;
				`BCM_OFS_B_DMASK: b_dmask_r <= apb_req.pwdata;
				`BCM_OFS_B_CTRL: b_data_en_r <= apb_req.pwdata[`BCM_FLD_DATA_EN];
				default: b_data_en_r <= b_data_en_r;
			endcase
		end
	end

	// Channel A: attributes plus masked address on the main bus.
	always_comb begin
		a_hit = bus_cycle.valid &&
			attr_ok(a_cyc_r[7:0], bus_cycle.is_dma, bus_cycle.is_fetch,
				bus_cycle.is_write, bus_cycle.size) &&
			(((bus_cycle.addr ^ a_addr_r) & ~a_amask_r) == 32'h0000_0000);
	end

	// Channel B: main bus or one of the X/Y buses.
	always_comb begin
		logic [15:0] ref_a;
		logic [15:0] msk_a;
		logic [15:0] ref_d;
		logic [15:0] msk_d;
		ref_a = 16'h0000;
		msk_a = 16'h0000;
		ref_d = 16'h0000;
		msk_d = 16'h0000;
		b_hit = 1'b0;
		if (!b_cyc_r[`BCM_FLD_XY_EN]) begin
			b_hit = bus_cycle.valid &&
				attr_ok(b_cyc_r[7:0], bus_cycle.is_dma, bus_cycle.is_fetch,
					bus_cycle.is_write, bus_cycle.size) &&
				(((bus_cycle.addr ^ b_addr_r) & ~b_amask_r) == 32'h0000_0000) &&
				(!b_data_en_r ||
				(((bus_cycle.data ^ b_data_r) & ~b_dmask_r) == 32'h0000_0000));
		end else begin
			if (b_cyc_r[`BCM_FLD_XY_SEL]) begin
				ref_a = b_addr_r[15:0];
				msk_a = b_amask_r[15:0];
				ref_d = b_data_r[15:0];
				msk_d = b_dmask_r[15:0];
			end else begin
				ref_a = b_addr_r[31:16];
				msk_a = b_amask_r[31:16];
				ref_d = b_data_r[31:16];
				msk_d = b_dmask_r[31:16];
			end
			b_hit = xy_cycle.valid && (xy_cycle.is_y == b_cyc_r[`BCM_FLD_XY_SEL]) &&
				attr_ok(b_cyc_r[7:0], xy_cycle.is_dma, xy_cycle.is_fetch,
					xy_cycle.is_write, bcm_pkg::BCM_SZ_WORD) &&
				(((xy_cycle.addr[15:1] ^ ref_a[15:1]) & ~msk_a[15:1]) == 15'h0000) &&
				(!b_data_en_r ||
				(((xy_cycle.data ^ ref_d) & ~msk_d) == 16'h0000));
		end
	end

	// Match outputs follow the hits for as long as they last, registered one edge after the bus cycle.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			match_a <= 1'b0;
			match_b <= 1'b0;
		end else begin
			match_a <= a_hit;
			match_b <= b_hit;
		end
	end
endmodule

//--- logic/bcm_pkg.sv
// Types shared by the break matcher and its bench.
package bcm_pkg;
	typedef enum logic [1:0] {
		BCM_SZ_ANY = 2'h0,
		BCM_SZ_BYTE = 2'h1,
		BCM_SZ_WORD = 2'h2,
		BCM_SZ_LONG = 2'h3
	} bcm_size_t;

	typedef struct packed {
		logic valid;
		logic is_dma;
		logic is_fetch;
		logic is_write;
		bcm_size_t size;
		logic [31:0] addr;
		logic [31:0] data;
	} bcm_cycle_t;

	typedef struct packed {
		logic valid;
		logic is_y;
		logic is_dma;
		logic is_fetch;
		logic is_write;
		logic [15:0] addr;
		logic [15:0] data;
	} bcm_xy_cycle_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} bcm_apb_req_t;
endpackage
